// file: logic/host_bridge_suspend_resume.sv
// Suspend/resume sequencer: refresh mode, buffer isolation, resets and suspend pin levels.
`timescale 1ns/1ps
module host_bridge_suspend_resume
#(
   parameter int unsigned CPU_RESET_CYCLES = suspend_resume_pkg::CPU_RESET_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_suspend_status_n,
   input wire logic i_pci_reset_n,
   input wire logic i_bridge_power_good,
   input wire suspend_resume_pkg::cfg_s i_cfg,
   input wire logic i_self_refresh_done,
   input wire logic i_cycle_active,
   output logic o_processor_reset_n,
   output logic o_internal_reset_n,
   output logic o_normal_refresh_enable,
   output logic o_suspend_refresh,
   output logic o_buffers_isolated,
   output suspend_resume_pkg::mem_pins_s o_mem_pins,
   output logic o_mem_pins_forced,
   output logic o_bank_b_addr_oe_n,
   output logic o_memory_data_oe_n
);
   import suspend_resume_pkg::*;

   localparam int unsigned STEP_CYC = SUSPEND_STEPS;

   logic sus_n;
   logic sus_fall;
   logic sus_rise;
   logic pci_n;
   logic pci_fall;
   logic pci_rise;
   logic pg_meta_r;
   logic pg_r;

   // Edge detection on both partner-driven inputs.
   sync_edge u_sus
   (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_async(i_suspend_status_n),
      .o_level(sus_n),
      .o_fall(sus_fall),
      .o_rise(sus_rise)
   );

   sync_edge u_pci
   (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_async(i_pci_reset_n),
      .o_level(pci_n),
      .o_fall(pci_fall),
      .o_rise(pci_rise)
   );

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pg_meta_r <= 1'b0;
         pg_r <= 1'b0;
      end
      else
      begin
         pg_meta_r <= i_bridge_power_good;
         pg_r <= pg_meta_r;
      end
   end

   seq_state_e state_r;
   seq_state_e state_nxt;
   logic [TIMER_W-1:0] step_r;
   logic [TIMER_W-1:0] step_nxt;
   logic nref_r;
   logic nref_nxt;
   logic srf_r;
   logic srf_nxt;
   logic iso_r;
   logic iso_nxt;
   logic irst_n_r;
   logic irst_n_nxt;
   logic [31:0] crst_cnt_r;
   logic [31:0] crst_cnt_nxt;
   logic crst_n_r;
   logic crst_n_nxt;
   logic hard_reset;

   // Synchronised partner resets force processor reset in the next clock.
   assign hard_reset = ~pg_r | ~pci_n | pci_fall;

   always_comb
   begin
      state_nxt = state_r;
      step_nxt = step_r;
      nref_nxt = nref_r;
      srf_nxt = srf_r;
      iso_nxt = iso_r;
      irst_n_nxt = 1'b1;
      unique case (state_r)
         ST_RUN:
         begin
            if (sus_fall && pci_n)
            begin
               state_nxt = ST_ENTER;
               step_nxt = '0;
               srf_nxt = 1'b1;
               nref_nxt = 1'b0;
            end
         end
         ST_ENTER:
         begin
            // Refresh switch first, then isolation, both well under 32 us.
            step_nxt = step_r + 1'b1;
            srf_nxt = 1'b1;
            nref_nxt = 1'b0;
            if (step_r == TIMER_W'(STEP_CYC - 1))
            begin
               iso_nxt = 1'b1;
               state_nxt = ST_SUSP;
            end
         end
         ST_SUSP:
         begin
            if (sus_rise)
            begin
               // Buffers back one clock after the detected edge.
               iso_nxt = 1'b0;
               state_nxt = ST_RESUME;
               if (!pci_n)
               begin
                  irst_n_nxt = 1'b0;
               end
            end
         end
         ST_RESUME:
         begin
            state_nxt = ST_RUN;
            if (pci_n)
            begin
               srf_nxt = 1'b0;
               nref_nxt = 1'b1;
            end
         end
         default:
         begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always_comb
   begin
      crst_cnt_nxt = crst_cnt_r;
      crst_n_nxt = crst_n_r;
      if (hard_reset)
      begin
         crst_n_nxt = 1'b0;
         crst_cnt_nxt = CPU_RESET_CYCLES;
      end
      else if (state_r == ST_SUSP && sus_rise && i_cfg.processor_reset_on_resume_en)
      begin
         crst_n_nxt = 1'b0;
         crst_cnt_nxt = CPU_RESET_CYCLES;
      end
      else if (!crst_n_r)
      begin
         // Count down the 1 ms hold after PCI reset release or resume.
         if (crst_cnt_r <= 32'h00000001)
         begin
            crst_n_nxt = 1'b1;
            crst_cnt_nxt = '0;
         end
         else
         begin
            crst_cnt_nxt = crst_cnt_r - 32'h00000001;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         state_r <= ST_RUN;
         step_r <= '0;
         nref_r <= RST_NREF;
         srf_r <= 1'b0;
         iso_r <= 1'b0;
         irst_n_r <= 1'b0;
         crst_cnt_r <= '0;
         crst_n_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         step_r <= step_nxt;
         nref_r <= nref_nxt;
         srf_r <= srf_nxt;
         iso_r <= iso_nxt;
         irst_n_r <= irst_n_nxt;
         crst_cnt_r <= crst_cnt_nxt;
         crst_n_r <= crst_n_nxt;
      end
   end

   mem_pins_s pins_nxt;
   mem_pins_s pins_r;
   logic forced_nxt;
   logic forced_r;
   logic ba_oe_n_r;
   logic md_oe_n_r;

   always_comb
   begin
      pins_nxt = '{row_cs_n: 1'b1, col_dqm_n: 1'b1, clock_enable: 1'b1, global_clock_enable: 1'b1,
                   sdram_row_strobe_n: 1'b1, sdram_column_strobe_n: 1'b1, write_enable_n: 1'b1};
      forced_nxt = 1'b0;
      if (iso_r)
      begin
         // SDRAM levels first, EDO the opposite; write enables high.
         pins_nxt.clock_enable = ~i_cfg.sdram_mode;
         pins_nxt.global_clock_enable = ~i_cfg.sdram_mode;
         pins_nxt.sdram_row_strobe_n = ~i_cfg.sdram_mode;
         pins_nxt.sdram_column_strobe_n = i_cfg.sdram_mode;
         pins_nxt.write_enable_n = 1'b1;
         if (i_cfg.sdram_mode)
         begin
            forced_nxt = i_self_refresh_done;
         end
         else if (i_cfg.edo_self_refresh)
         begin
            pins_nxt.row_cs_n = 1'b0;
            pins_nxt.col_dqm_n = 1'b0;
            forced_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pins_r <= '1;
         forced_r <= 1'b0;
         ba_oe_n_r <= 1'b1;
         md_oe_n_r <= 1'b1;
      end
      else
      begin
         pins_r <= pins_nxt;
         forced_r <= forced_nxt;
         ba_oe_n_r <= ~irst_n_r;
         md_oe_n_r <= i_cycle_active;
      end
   end

   assign o_processor_reset_n = crst_n_r;
   assign o_internal_reset_n = irst_n_r;
   assign o_normal_refresh_enable = nref_r;
   assign o_suspend_refresh = srf_r;
   assign o_buffers_isolated = iso_r;
   assign o_mem_pins = pins_r;
   assign o_mem_pins_forced = forced_r;
   assign o_bank_b_addr_oe_n = ba_oe_n_r;
   assign o_memory_data_oe_n = md_oe_n_r;

   sequence sus_edge_s;
      (state_r == ST_RUN) && sus_fall && pci_n;
   endsequence

   sequence resume_s;
      (state_r == ST_SUSP) && sus_rise;
   endsequence

   isolate_deadline_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      sus_edge_s |-> ##[1:20] iso_r) else $error("Buffers not isolated in time.");

   refresh_enter_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      sus_edge_s |=> srf_r && !nref_r) else $error("Suspend refresh not entered.");

   buffer_valid_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      resume_s |=> !iso_r) else $error("Buffers not valid after resume.");

   reset_resume_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (resume_s and (!pci_n)) |=> !irst_n_r ##1 (srf_r && !nref_r)) else $error("Reset resume wrong.");

   auto_resume_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (resume_s and (pci_n)) |-> ##2 (nref_r && !srf_r)) else $error("Automatic resume missing.");

   cpu_reset_resume_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      (resume_s and (i_cfg.processor_reset_on_resume_en)) |-> ##[1:4] !crst_n_r) else $error("No resume reset.");

   pci_cpu_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      pci_fall |=> !crst_n_r) else $error("Processor reset late.");

   cpu_reset_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      $rose(crst_n_r) |-> $past(crst_cnt_r) == 32'h00000001) else $error("Processor reset short.");

   suspend_pins_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
      iso_r && i_cfg.sdram_mode |=> !pins_r.global_clock_enable && pins_r.sdram_column_strobe_n)
      else $error("Suspend pin levels wrong.");
endmodule // host_bridge_suspend_resume

// file: logic/suspend_resume_pkg.sv
// Package with constants and carriers for the suspend/resume sequencer.
package suspend_resume_pkg;

   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned SUSPEND_WINDOW_US = 32;
   localparam int unsigned CPU_RESET_MS = 1;
   localparam int unsigned RESUME_BUFFER_HCLK = 2;
   localparam int unsigned CPU_RESET_LATE_HCLK = 4;
   // Suspend actions finish well inside the 32 us window; a small step count is used.
   localparam int unsigned SUSPEND_STEPS = 8;
   localparam int unsigned SUSPEND_WINDOW_CYC = SUSPEND_WINDOW_US * CLK_MHZ;
   localparam int unsigned CPU_RESET_CYC = CPU_RESET_MS * 1000 * CLK_MHZ;
   localparam int unsigned TIMER_W = 16;

   localparam logic RST_NREF = 1'b1;

   typedef enum logic [3:0]
   {
      ST_RUN = 4'h1,
      ST_ENTER = 4'h2,
      ST_SUSP = 4'h4,
      ST_RESUME = 4'h8
   } seq_state_e;

   // Static pin levels held while suspended.
   typedef struct packed
   {
      logic row_cs_n;
      logic col_dqm_n;
      logic clock_enable;
      logic global_clock_enable;
      logic sdram_row_strobe_n;
      logic sdram_column_strobe_n;
      logic write_enable_n;
   } mem_pins_s;

   // Configuration strap inputs.
   typedef struct packed
   {
      logic sdram_mode;
      logic edo_self_refresh;
      logic processor_reset_on_resume_en;
   } cfg_s;

endpackage

// file: logic/sync_edge.sv
// Two-flop synchroniser with edge detection for one active-low input.
`timescale 1ns/1ps
module sync_edge
(
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_async,
   output logic o_level,
   output logic o_fall,
   output logic o_rise
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge i_mclk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         meta_r <= i_async;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign o_level = sync_r;
   assign o_fall = prev_r & ~sync_r;
   assign o_rise = ~prev_r & sync_r;
endmodule // sync_edge

// file: verification/host_bridge_suspend_resume_test.sv
// Self-checking testbench for the suspend/resume sequencer.
`timescale 1ns/1ps
module host_bridge_suspend_resume_test;
   import suspend_resume_pkg::*;
   localparam int unsigned CPU_RST = 50;
   localparam int unsigned SYNC = 3;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_bridge_power_good = 1'b0;
   cfg_s i_cfg = 3'h4;
   logic i_self_refresh_done = 1'b0;
   logic i_cycle_active = 1'b0;
   wire logic suspend_status_n;
   wire logic pci_reset_n;
   logic o_processor_reset_n, o_internal_reset_n, o_normal_refresh_enable, o_suspend_refresh;
   logic o_buffers_isolated, o_mem_pins_forced, o_bank_b_addr_oe_n, o_memory_data_oe_n;
   mem_pins_s o_mem_pins;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_ireset = 0;
   int n_preset = 0;
   host_bridge_suspend_resume #(.CPU_RESET_CYCLES(CPU_RST)) i_host_bridge_suspend_resume
   (
      .i_mclk(i_mclk), .i_rstn(i_rstn), .i_suspend_status_n(suspend_status_n), .i_pci_reset_n(pci_reset_n),
      .i_bridge_power_good(i_bridge_power_good), .i_cfg(i_cfg), .i_self_refresh_done(i_self_refresh_done),
      .i_cycle_active(i_cycle_active), .o_processor_reset_n(o_processor_reset_n),
      .o_internal_reset_n(o_internal_reset_n), .o_normal_refresh_enable(o_normal_refresh_enable),
      .o_suspend_refresh(o_suspend_refresh), .o_buffers_isolated(o_buffers_isolated), .o_mem_pins(o_mem_pins),
      .o_mem_pins_forced(o_mem_pins_forced), .o_bank_b_addr_oe_n(o_bank_b_addr_oe_n),
      .o_memory_data_oe_n(o_memory_data_oe_n)
   );
   sb_power_model #(.HOLD_CYC(60)) i_sb_power_model
   (
      .i_mclk(i_mclk), .o_suspend_status_n(suspend_status_n), .o_pci_reset_n(pci_reset_n)
   );
   initial
   begin
      forever #12.5 i_mclk = ~i_mclk;
   end
   // Low cycles of both reset outputs are counted after the bench reset is released.
   always @(posedge i_mclk)
   begin
      if (i_rstn && o_internal_reset_n === 1'b0) n_ireset++;
      if (i_rstn && o_processor_reset_n === 1'b0) n_preset++;
   end
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return o_processor_reset_n;
         1: return o_suspend_refresh;
         2: return o_buffers_isolated;
         default: return o_normal_refresh_enable;
      endcase
   endfunction
   // Waits on the falling edge until the chosen output shows v, giving up after lim cycles.
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (pick(k) !== v && n < lim)
      begin
         @(negedge i_mclk);
         n++;
      end
      chk(pick(k) === v, "output did not reach expected level in time");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_power_up();
      int n;
      chk(o_processor_reset_n === 1'b0, "processor reset not low in reset");
      chk(o_bank_b_addr_oe_n === 1'b1, "bank B address driven in reset");
      chk(o_normal_refresh_enable === RST_NREF && o_suspend_refresh === 1'b0, "refresh reset state");
      @(negedge i_mclk);
      i_rstn = 1'b1;
      repeat (5) @(negedge i_mclk);
      chk(o_processor_reset_n === 1'b0, "processor reset released with power good low");
      i_bridge_power_good = 1'b1;
      wait_for(0, 1'b1, CPU_RST + 20, n);
      chk(n >= CPU_RST, "processor reset too short after power good");
      chk(o_bank_b_addr_oe_n === 1'b0 && o_buffers_isolated === 1'b0, "outputs not driven after reset");
      $display("test power_up done");
   endtask
   task automatic t_data_drive();
      i_cycle_active = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(o_memory_data_oe_n === 1'b1, "data driven during a cycle");
      i_cycle_active = 1'b0;
      repeat (3) @(negedge i_mclk);
      chk(o_memory_data_oe_n === 1'b0, "data not driven while idle");
      $display("test data_drive done");
   endtask
   task automatic t_refused();
      int n;
      i_sb_power_model.set_pci(1'b0);
      wait_for(0, 1'b0, SYNC + 2, n);
      i_sb_power_model.suspend();
      repeat (30) @(negedge i_mclk);
      chk(o_suspend_refresh === 1'b0 && o_buffers_isolated === 1'b0, "suspend taken under PCI reset");
      i_sb_power_model.resume();
      i_sb_power_model.set_pci(1'b1);
      wait_for(0, 1'b1, CPU_RST + 20, n);
      chk(n >= CPU_RST, "processor reset too short after PCI reset");
      $display("test refused done");
   endtask
   task automatic t_cycle(input cfg_s c, input logic with_reset);
      int n;
      int ir0;
      int pr0;
      mem_pins_s e;
      i_cfg = c;
      i_self_refresh_done = 1'b1;
      e = c.sdram_mode ? 7'h63 : (c.edo_self_refresh ? 7'h1D : 7'h7D);
      i_sb_power_model.suspend();
      wait_for(1, 1'b1, SUSPEND_WINDOW_CYC, n);
      chk(o_normal_refresh_enable === 1'b0, "normal refresh still enabled in suspend");
      wait_for(2, 1'b1, SUSPEND_WINDOW_CYC, n);
      repeat (3) @(negedge i_mclk);
      chk(o_mem_pins_forced === (c.sdram_mode | c.edo_self_refresh) && o_mem_pins === e, "suspend pins");
      if (with_reset)
      begin
         i_sb_power_model.set_pci(1'b0);
         wait_for(0, 1'b0, SYNC + 2, n);
      end
      ir0 = n_ireset;
      pr0 = n_preset;
      i_sb_power_model.resume();
      wait_for(2, 1'b0, SYNC + RESUME_BUFFER_HCLK, n);
      if (with_reset)
      begin
         repeat (10) @(negedge i_mclk);
         chk(o_suspend_refresh === 1'b1 && o_normal_refresh_enable === 1'b0, "refresh left suspend");
         chk(n_ireset == ir0 + 1, "internal reset pulse missing");
         i_sb_power_model.set_pci(1'b1);
         wait_for(0, 1'b1, CPU_RST + 20, n);
         chk(n >= CPU_RST, "processor reset too short after resume");
      end
      else
      begin
         // The bench starts no memory cycle until normal refresh is back, as the stop-clock hold intends.
         wait_for(3, 1'b1, SUSPEND_WINDOW_CYC, n);
         chk(o_suspend_refresh === 1'b0 && n_ireset == ir0, "automatic resume state");
         if (c.processor_reset_on_resume_en)
         begin
            chk(n_preset > pr0 && n_preset - pr0 <= CPU_RESET_LATE_HCLK, "processor reset late");
            wait_for(0, 1'b1, CPU_RST + 20, n);
            chk(n_preset - pr0 >= CPU_RST, "processor reset pulse short");
         end
         else
         begin
            repeat (CPU_RST) @(negedge i_mclk);
            chk(n_preset == pr0, "processor reset without enable");
         end
      end
      $display("test cycle done");
   endtask
   initial
   begin
      #750000;
      n_mismatch++;
      $display("ERROR at %0t: watchdog expired", $time);
      final_report();
   end
   initial
   begin
      repeat (2) @(negedge i_mclk);
      t_power_up();
      t_data_drive();
      t_refused();
      t_cycle(3'h4, 1'b0);
      t_cycle(3'h3, 1'b0);
      t_cycle(3'h0, 1'b0);
      t_cycle(3'h5, 1'b1);
      final_report();
   end
endmodule // host_bridge_suspend_resume_test

// file: verification/sb_power_model.sv
// Model of the south-bridge power controller that drives suspend status and PCI reset.
`timescale 1ns/1ps
module sb_power_model
#(
   parameter int unsigned HOLD_CYC = 60
)
(
   input wire logic i_mclk,
   output logic o_suspend_status_n,
   output logic o_pci_reset_n
);
   // Levels change on the falling edge only; this model never stops the clocks.
   initial
   begin
      o_suspend_status_n = 1'b1;
      o_pci_reset_n = 1'b1;
   end
   task automatic set_pci(input logic v);
      @(negedge i_mclk);
      o_pci_reset_n = v;
   endtask
   task automatic suspend();
      @(negedge i_mclk);
      o_suspend_status_n = 1'b0;
   endtask
   // Stable power and clocks are held for a scaled stand-in of the minimum before resume.
   task automatic resume();
      repeat (HOLD_CYC) @(negedge i_mclk);
      o_suspend_status_n = 1'b1;
   endtask
endmodule // sb_power_model
